/* File: hdl/fbp_pkg.sv */
// Shared constants and types for the flash block-protection host controller.
// Assumes a 250 MHz system clock and a x16 parallel NOR flash on the pins.
package fbp_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ          = 250;
	localparam int T_BUS_NS         = 70;
	localparam int T_REC_NS         = 20;
	localparam int T_UNLOCK_GAP_NS  = 1000;
	localparam int T_UNLOCK_DONE_NS = 1000;
	localparam int BUS_CYC   = (T_BUS_NS * CLK_MHZ + 999) / 1000;
	localparam int RD_CYC    = BUS_CYC + 2;
	localparam int REC_CYC   = (T_REC_NS * CLK_MHZ + 999) / 1000;
	localparam int GAP_CYC   = (T_UNLOCK_GAP_NS * CLK_MHZ + 999) / 1000;
	localparam int SETTLE_CYC = (T_UNLOCK_DONE_NS * CLK_MHZ + 999) / 1000;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int AW = 24;
	localparam int DW = 16;

	// ----------------------------------------------------------------
	// Register offsets and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_WDATA  = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_PWD_LO = 8'h10;
	localparam logic [7:0] REG_PWD_HI = 8'h14;
	localparam logic [7:0] REG_RD_LO  = 8'h18;
	localparam logic [7:0] REG_RD_HI  = 8'h1C;
	localparam int CTRL_GO_BIT  = 8;
	localparam int CTRL_WP_BIT  = 16;
	localparam int CTRL_ACC_BIT = 17;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	// ----------------------------------------------------------------
	// Flash command codes and addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] CODE_LOCKREG = 8'h40;
	localparam logic [7:0] CODE_PWD     = 8'h60;
	localparam logic [7:0] CODE_NVP     = 8'hC0;
	localparam logic [7:0] CODE_LOCKBIT = 8'h50;
	localparam logic [7:0] CODE_VOL     = 8'hE0;
	localparam logic [7:0] CODE_EXT     = 8'h88;
	localparam logic [7:0] CODE_EXIT    = 8'h90;
	localparam logic [7:0] CODE_EXIT2   = 8'h00;
	localparam logic [7:0] CODE_PROG    = 8'hA0;
	localparam logic [7:0] CODE_CLR1    = 8'h80;
	localparam logic [7:0] CODE_CLR2    = 8'h30;
	localparam logic [7:0] CODE_UNL1    = 8'h25;
	localparam logic [7:0] CODE_UNL2    = 8'h03;
	localparam logic [7:0] CODE_UNL_END = 8'h29;
	localparam logic [7:0] CODE_KEY1    = 8'hAA;
	localparam logic [7:0] CODE_KEY2    = 8'h55;
	localparam logic [7:0] DATA_PROTECT = 8'h00;
	localparam logic [7:0] DATA_CLR_VOL = 8'h01;
	localparam logic [AW-1:0] ADDR_KEY1 = 24'h000555;
	localparam logic [AW-1:0] ADDR_KEY2 = 24'h0002AA;
	localparam logic [AW-1:0] ADDR_ZERO = 24'h000000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_ENTER_LOCKREG, OP_ENTER_PWD, OP_ENTER_NVP, OP_ENTER_LOCKBIT,
		OP_ENTER_VOL, OP_ENTER_EXT, OP_EXIT, OP_PROGRAM, OP_CLEAR_VOL,
		OP_READ, OP_CLEAR_NVP, OP_UNLOCK_PWD, OP_PROG_PWD, OP_READ_PWD
	} fbp_op_t;

	typedef enum logic [2:0] {
		MODE_READ, MODE_LOCKREG, MODE_PWD, MODE_NVP, MODE_LOCKBIT,
		MODE_VOL, MODE_EXT
	} fbp_mode_t;

	typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT_BUS, ST_SETTLE}
		fbp_state_t;

	typedef enum logic [1:0] {PH_IDLE, PH_STROBE, PH_RECOVER} fbp_phase_t;

	typedef struct packed {
		logic [AW-1:0] addr;
		logic [DW-1:0] data;
		logic          rd;
		logic          last;
	} fbp_cyc_t;

endpackage

/* File: hdl/fbp_bus_cycle.sv */
// One asynchronous flash bus cycle (read or write) on the parallel pins.
// Assumes the flash answers within T_BUS_NS of chip and output enable.
`timescale 1ns/10ps
module fbp_bus_cycle
	import fbp_pkg::*;
(
	// Clock and reset
	input  wire logic          clk_i,
	input  wire logic          sys_rst_i,
	// Cycle request
	input  wire logic          start_i,
	input  wire logic          rd_i,
	input  wire logic [AW-1:0] addr_i,
	input  wire logic [DW-1:0] data_i,
	output logic               done_o,
	output logic [DW-1:0]      rdata_o,
	// Flash pins
	input  wire logic [DW-1:0] dq_i,
	output logic [AW-1:0]      addr_o,
	output logic [DW-1:0]      dq_o,
	output logic               dq_oe_o,
	output logic               ce_n_o,
	output logic               oe_n_o,
	output logic               we_n_o
);
	import fbp_pkg::*;

	typedef struct packed {
		fbp_phase_t    phase;
		logic [7:0]    cnt;
		logic          rd;
		logic [AW-1:0] addr;
		logic [DW-1:0] dq;
		logic          oe;
		logic          ce_n;
		logic          oe_n;
		logic          we_n;
		logic          done;
		logic [DW-1:0] rdata;
		logic [DW-1:0] sync1;
		logic [DW-1:0] sync2;
	} fbp_bus_s_t;

	localparam fbp_bus_s_t BUS_RST = '{phase: PH_IDLE, cnt: 8'h00,
		rd: 1'b0, addr: '0, dq: '0, oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1,
		we_n: 1'b1, done: 1'b0, rdata: '0, sync1: '0, sync2: '0};

	fbp_bus_s_t s_reg;
	fbp_bus_s_t s_next;

	always_comb
	begin
		s_next       = s_reg;
		s_next.done  = 1'b0;
		// Two-stage synchroniser on the data pins
		s_next.sync1 = dq_i;
		s_next.sync2 = s_reg.sync1;
		case (s_reg.phase)
			PH_IDLE:
			begin
				if (start_i)
				begin
					s_next.addr  = addr_i;
					s_next.dq    = data_i;
					s_next.rd    = rd_i;
					s_next.oe    = ~rd_i;
					s_next.ce_n  = 1'b0;
					s_next.oe_n  = ~rd_i;
					s_next.we_n  = rd_i;
					s_next.cnt   = rd_i ? 8'(RD_CYC) : 8'(BUS_CYC);
					s_next.phase = PH_STROBE;
				end
			end
			PH_STROBE:
			begin
				if (s_reg.cnt == 8'h01)
				begin
					// Sync delay is covered by RD_CYC
					if (s_reg.rd)
						s_next.rdata = s_reg.sync2;
					s_next.oe_n  = 1'b1;
					s_next.we_n  = 1'b1;
					s_next.cnt   = 8'(REC_CYC);
					s_next.phase = PH_RECOVER;
				end
				else
					s_next.cnt = s_reg.cnt - 8'h01;
			end
			PH_RECOVER:
			begin
				// Data held past the strobe edge for hold time
				if (s_reg.cnt == 8'h01)
				begin
					s_next.ce_n  = 1'b1;
					s_next.oe    = 1'b0;
					s_next.done  = 1'b1;
					s_next.phase = PH_IDLE;
				end
				else
					s_next.cnt = s_reg.cnt - 8'h01;
			end
			default:
				s_next = BUS_RST;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			s_reg <= BUS_RST;
		else
			s_reg <= s_next;
	end

	assign done_o  = s_reg.done;
	assign rdata_o = s_reg.rdata;
	assign addr_o  = s_reg.addr;
	assign dq_o    = s_reg.dq;
	assign dq_oe_o = s_reg.oe;
	assign ce_n_o  = s_reg.ce_n;
	assign oe_n_o  = s_reg.oe_n;
	assign we_n_o  = s_reg.we_n;

endmodule

/* File: hdl/fbp_ctrl_top.sv */
// Host controller for flash block protection: AHB-Lite registers in,
// command sequences out on the flash's parallel pins (x16 wiring).
// Assumes one AHB master and a single x16 flash on the pins.
//
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/10ps
module fbp_ctrl_top
	import fbp_pkg::*;
(
	// Clock and reset
	input  wire logic          clk_i,
	input  wire logic          sys_rst_i,
	// AHB-Lite slave
	input  wire logic          hsel_i,
	input  wire logic [31:0]   haddr_i,
	input  wire logic [1:0]    htrans_i,
	input  wire logic          hwrite_i,
	input  wire logic [2:0]    hsize_i,
	input  wire logic [31:0]   hwdata_i,
	input  wire logic          hready_i,
	output logic               hreadyout_o,
	output logic [31:0]        hrdata_o,
	output logic               hresp_o,
	// Flash pins
	input  wire logic [DW-1:0] flash_dq_i,
	output logic [DW-1:0]      flash_dq_o,
	output logic               flash_dq_oe_o,
	output logic [AW-1:0]      flash_addr_o,
	output logic               flash_ce_n_o,
	output logic               flash_oe_n_o,
	output logic               flash_we_n_o,
	output logic               flash_wp_n_o,
	output logic               accel_program_voltage_level_o
);
	import fbp_pkg::*;

	typedef struct packed {
		logic          wr_q;
		logic [7:0]    waddr_q;
		logic          hready;
		logic [31:0]   hrdata;
		fbp_state_t    state;
		fbp_op_t       op;
		fbp_mode_t     mode;
		logic [3:0]    step;
		logic          err;
		logic          start;
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
		logic [63:0]   pwd;
		logic [63:0]   rdbuf;
		logic [8:0]    gap;
		logic [8:0]    settle;
		logic          wp_n;
		logic          accel;
	} fbp_ctrl_s_t;

	localparam fbp_ctrl_s_t CTRL_RST = '{wr_q: 1'b0, waddr_q: 8'h00,
		hready: 1'b1, hrdata: 32'h00000000, state: ST_IDLE,
		op: OP_READ, mode: MODE_READ, step: 4'h0, err: 1'b0,
		start: 1'b0, addr: '0, wdata: '0, pwd: '1, rdbuf: '0,
		gap: 9'(GAP_CYC), settle: 9'h000, wp_n: 1'b1, accel: 1'b0};

	fbp_ctrl_s_t s_reg;
	fbp_ctrl_s_t s_next;
	fbp_cyc_t    cyc;
	logic        bus_done;
	logic [DW-1:0] bus_rdata;
	logic        accept;
	logic        op_ok;
	fbp_op_t     new_op;

	// ----------------------------------------------------------------
	// Command sequence table
	// ----------------------------------------------------------------
	function automatic fbp_cyc_t mk(input logic [AW-1:0] a,
		input logic [7:0] d, input logic rd, input logic last);
		mk = '{addr: a, data: {8'h00, d}, rd: rd, last: last};
	endfunction

	function automatic logic [7:0] enter_code(input fbp_op_t op);
		case (op)
			OP_ENTER_LOCKREG: enter_code = CODE_LOCKREG;
			OP_ENTER_PWD:     enter_code = CODE_PWD;
			OP_ENTER_NVP:     enter_code = CODE_NVP;
			OP_ENTER_LOCKBIT: enter_code = CODE_LOCKBIT;
			OP_ENTER_VOL:     enter_code = CODE_VOL;
			default:          enter_code = CODE_EXT;
		endcase
	endfunction

	function automatic fbp_cyc_t seq(input fbp_op_t op,
		input fbp_mode_t mode, input logic [3:0] st,
		input logic [AW-1:0] a, input logic [DW-1:0] wd,
		input logic [63:0] pw);
		logic [1:0] w;
		w   = 2'h0;
		seq = mk(ADDR_ZERO, 8'h00, 1'b1, 1'b1);
		case (op)
			OP_ENTER_LOCKREG, OP_ENTER_PWD, OP_ENTER_NVP,
			OP_ENTER_LOCKBIT, OP_ENTER_VOL, OP_ENTER_EXT:
				case (st)
					4'h0:    seq = mk(ADDR_KEY1, CODE_KEY1, 1'b0, 1'b0);
					4'h1:    seq = mk(ADDR_KEY2, CODE_KEY2, 1'b0, 1'b0);
					default: seq = mk(ADDR_KEY1, enter_code(op), 1'b0, 1'b1);
				endcase
			OP_EXIT:
				// Extended mode needs the keyed form of exit
				if (mode == MODE_EXT)
					case (st)
						4'h0:    seq = mk(ADDR_KEY1, CODE_KEY1, 1'b0, 1'b0);
						4'h1:    seq = mk(ADDR_KEY2, CODE_KEY2, 1'b0, 1'b0);
						4'h2:    seq = mk(ADDR_KEY1, CODE_EXIT, 1'b0, 1'b0);
						default: seq = mk(ADDR_ZERO, CODE_EXIT2, 1'b0, 1'b1);
					endcase
				else if (st == 4'h0)
					seq = mk(ADDR_ZERO, CODE_EXIT, 1'b0, 1'b0);
				else
					seq = mk(ADDR_ZERO, CODE_EXIT2, 1'b0, 1'b1);
			OP_PROGRAM, OP_CLEAR_VOL:
				if (st == 4'h0)
					seq = mk(ADDR_ZERO, CODE_PROG, 1'b0, 1'b0);
				else
				begin
					seq = mk(a, DATA_CLR_VOL, 1'b0, 1'b1);
					if (op == OP_PROGRAM)
						seq.data = wd;
				end
			OP_READ:
				seq = mk(a, 8'h00, 1'b1, 1'b1);
			OP_CLEAR_NVP:
				if (st == 4'h0)
					seq = mk(ADDR_ZERO, CODE_CLR1, 1'b0, 1'b0);
				else
					seq = mk(ADDR_ZERO, CODE_CLR2, 1'b0, 1'b1);
			OP_UNLOCK_PWD:
				case (st)
					4'h0:    seq = mk(ADDR_ZERO, CODE_UNL1, 1'b0, 1'b0);
					4'h1:    seq = mk(ADDR_ZERO, CODE_UNL2, 1'b0, 1'b0);
					4'h6:    seq = mk(ADDR_ZERO, CODE_UNL_END, 1'b0, 1'b1);
					default:
					begin
						w   = 2'(st - 4'h2);
						seq = mk(AW'(w), 8'h00, 1'b0, 1'b0);
						seq.data = pw[{w, 4'h0} +: 16];
					end
				endcase
			OP_PROG_PWD:
				// Four A0h writes at address 0, each followed by a password word at word addresses 0 to 3
				if (!st[0])
					seq = mk(ADDR_ZERO, CODE_PROG, 1'b0, 1'b0);
				else
				begin
					w   = st[2:1];
					seq = mk(AW'(w), 8'h00, 1'b0, st[3:1] == 3'h3);
					seq.data = pw[{w, 4'h0} +: 16];
				end
			OP_READ_PWD:
				seq = mk(AW'(st[1:0]), 8'h00, 1'b1, st[1:0] == 2'h3);
			default:
				seq = mk(ADDR_ZERO, 8'h00, 1'b1, 1'b1);
		endcase
	endfunction

	// One mode at a time, commands only in their own mode, OP_READ in any mode
	function automatic logic legal(input fbp_op_t op, input fbp_mode_t m,
		input logic gap_ok);
		case (op)
			OP_ENTER_LOCKREG, OP_ENTER_PWD, OP_ENTER_NVP, OP_ENTER_LOCKBIT,
			OP_ENTER_VOL, OP_ENTER_EXT:
				legal = (m == MODE_READ);
			OP_EXIT:
				legal = (m != MODE_READ);
			OP_PROGRAM:
				legal = (m != MODE_READ) && (m != MODE_PWD);
			OP_CLEAR_VOL:
				legal = (m == MODE_VOL);
			OP_READ:
				legal = 1'b1;
			OP_CLEAR_NVP:
				legal = (m == MODE_NVP);
			OP_UNLOCK_PWD:
				legal = (m == MODE_PWD) && gap_ok;
			OP_PROG_PWD, OP_READ_PWD:
				legal = (m == MODE_PWD);
			default:
				legal = 1'b0;
		endcase
	endfunction

	function automatic fbp_mode_t mode_after(input fbp_op_t op,
		input fbp_mode_t m);
		case (op)
			OP_ENTER_LOCKREG: mode_after = MODE_LOCKREG;
			OP_ENTER_PWD:     mode_after = MODE_PWD;
			OP_ENTER_NVP:     mode_after = MODE_NVP;
			OP_ENTER_LOCKBIT: mode_after = MODE_LOCKBIT;
			OP_ENTER_VOL:     mode_after = MODE_VOL;
			OP_ENTER_EXT:     mode_after = MODE_EXT;
			OP_EXIT:          mode_after = MODE_READ;
			default:          mode_after = m;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	assign cyc    = seq(s_reg.op, s_reg.mode, s_reg.step, s_reg.addr,
		s_reg.wdata, s_reg.pwd);
	assign accept = hsel_i && htrans_i[1] && hready_i &&
		(hsize_i == HSIZE_WORD);
	assign new_op = fbp_op_t'(hwdata_i[3:0]);
	assign op_ok  = legal(new_op, s_reg.mode, s_reg.gap == 9'(GAP_CYC));

	always_comb
	begin
		s_next       = s_reg;
		s_next.start = 1'b0;
		s_next.wr_q  = accept && hwrite_i;
		if (accept)
			s_next.waddr_q = haddr_i[7:0];
		if (s_reg.gap != 9'(GAP_CYC))
			s_next.gap = s_reg.gap + 9'h001;

		if (accept && !hwrite_i)
			case (haddr_i[7:0])
				REG_CTRL:   s_next.hrdata = {14'h0000, s_reg.accel,
					s_reg.wp_n, 12'h000, s_reg.op};
				REG_ADDR:   s_next.hrdata = {8'h00, s_reg.addr};
				REG_WDATA:  s_next.hrdata = {16'h0000, s_reg.wdata};
				REG_STATUS: s_next.hrdata = {25'h0000000, s_reg.mode,
					2'h0, s_reg.err, s_reg.state != ST_IDLE};
				REG_PWD_LO: s_next.hrdata = s_reg.pwd[31:0];
				REG_PWD_HI: s_next.hrdata = s_reg.pwd[63:32];
				REG_RD_LO:  s_next.hrdata = s_reg.rdbuf[31:0];
				REG_RD_HI:  s_next.hrdata = s_reg.rdbuf[63:32];
				default:    s_next.hrdata = 32'h00000000;
			endcase

		// Data phase of a write; operands frozen while a sequence runs
		if (s_reg.wr_q)
		begin
			if (s_reg.state != ST_IDLE)
				s_next.err = 1'b1;
			else
				case (s_reg.waddr_q)
					REG_CTRL:
					begin
						s_next.wp_n = hwdata_i[CTRL_WP_BIT];
						if (hwdata_i[CTRL_GO_BIT])
						begin
							if (op_ok)
							begin
								s_next.op    = new_op;
								s_next.step  = 4'h0;
								s_next.err   = 1'b0;
								s_next.state = ST_ISSUE;
								if (new_op == OP_UNLOCK_PWD)
									s_next.gap = 9'h000;
							end
							else
								s_next.err = 1'b1;
						end
						// Acceleration only from read mode
						// Checked after GO so a refusal beats its clear
						if (hwdata_i[CTRL_ACC_BIT] && !s_reg.accel &&
							s_reg.mode != MODE_READ)
							s_next.err = 1'b1;
						else
							s_next.accel = hwdata_i[CTRL_ACC_BIT];
					end
					REG_ADDR:   s_next.addr  = hwdata_i[AW-1:0];
					REG_WDATA:  s_next.wdata = hwdata_i[DW-1:0];
					REG_PWD_LO: s_next.pwd[31:0]  = hwdata_i;
					REG_PWD_HI: s_next.pwd[63:32] = hwdata_i;
					default:    s_next.err = s_reg.err;
				endcase
		end

		case (s_reg.state)
			ST_IDLE:
				s_next.state = s_next.state;
			ST_ISSUE:
			begin
				s_next.start = 1'b1;
				s_next.state = ST_WAIT_BUS;
			end
			ST_WAIT_BUS:
				if (bus_done)
				begin
					if (cyc.rd)
					begin
						if (s_reg.op == OP_READ_PWD)
							s_next.rdbuf[{s_reg.step[1:0], 4'h0} +: 16] =
								bus_rdata;
						else
							s_next.rdbuf = {48'h0, bus_rdata};
					end
					if (!cyc.last)
					begin
						s_next.step  = s_reg.step + 4'h1;
						s_next.state = ST_ISSUE;
					end
					else if (s_reg.op == OP_UNLOCK_PWD)
					begin
						s_next.settle = 9'(SETTLE_CYC);
						s_next.state  = ST_SETTLE;
					end
					else
					begin
						s_next.mode  = mode_after(s_reg.op, s_reg.mode);
						s_next.state = ST_IDLE;
					end
				end
			ST_SETTLE:
				// Busy stays high until the unlock has taken hold
				if (s_reg.settle == 9'h001)
					s_next.state = ST_IDLE;
				else
					s_next.settle = s_reg.settle - 9'h001;
			default:
				s_next.state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			s_reg <= CTRL_RST;
		else
			s_reg <= s_next;
	end

	// ----------------------------------------------------------------
	// Flash bus cycle engine
	// ----------------------------------------------------------------
	fbp_bus_cycle u_bus (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.start_i   (s_reg.start),
		.rd_i      (cyc.rd),
		.addr_i    (cyc.addr),
		.data_i    (cyc.data),
		.done_o    (bus_done),
		.rdata_o   (bus_rdata),
		.dq_i      (flash_dq_i),
		.addr_o    (flash_addr_o),
		.dq_o      (flash_dq_o),
		.dq_oe_o   (flash_dq_oe_o),
		.ce_n_o    (flash_ce_n_o),
		.oe_n_o    (flash_oe_n_o),
		.we_n_o    (flash_we_n_o)
	);

	assign hreadyout_o = s_reg.hready;
	assign hrdata_o    = s_reg.hrdata;
	assign hresp_o     = 1'b0;
	assign flash_wp_n_o = s_reg.wp_n;
	assign accel_program_voltage_level_o = s_reg.accel;

endmodule

/* File: verification/fbp_flash_model.sv */
// Behavioural x16 flash: protection command sets and status reads.
// Assumes strobes follow the controller's cycle timing.
`timescale 1ns/10ps
module fbp_flash_model #(parameter int RD_DLY_NS = 20)
(
	// Pins seen from the flash
	input  wire logic [23:0] addr_i,
	input  wire logic [15:0] dq_i,
	input  wire logic        ce_n_i,
	input  wire logic        oe_n_i,
	input  wire logic        we_n_i,
	output wire logic [15:0] dq_o
);
	logic [7:0]   mode;
	logic [255:0] nvp;
	logic [255:0] vol;
	// Position of the password-mode lock bit is a free choice
	localparam int PWD_LOCK_BIT = 2;
	logic         lock;
	logic [15:0]  lr;
	logic [15:0]  pw[4];
	logic [15:0]  ext[128];
	logic [15:0]  last;
	logic [15:0]  rv;
	logic [111:0] sh;
	realtime      t_unl;
	int           too_close;

	initial
	begin
		mode = 8'h00;
		nvp = '1;
		vol = '1;
		lock = 1'b1;
		lr = '1;
		pw = '{default: 16'hFFFF};
		ext = '{default: 16'hFFFF};
		sh = '0;
		t_unl = -1.0e6;
		too_close = 0;
		last = 16'h0000;
	end

	// ----
	// Command decode at the end of each write strobe
	// ----
	always @(posedge we_n_i)
	begin : wr
		logic [7:0] d;
		logic [7:0] b;
		d = dq_i[7:0];
		b = addr_i[23:16];
		if (!ce_n_i)
		begin
			if (mode == 8'h00 && sh[23:16] == 8'hAA && sh[7:0] == 8'h55
				&& addr_i == 24'h000555)
				mode = d;
			else if (sh[7:0] == 8'h90 && d == 8'h00)
				mode = 8'h00;
			else if (sh[7:0] == 8'hA0)
				case (mode)
				8'hC0: nvp[b] = 1'b0;
				8'h50: lock = 1'b0;
				8'hE0: vol[b] = d[0];
				8'h60: pw[addr_i[1:0]] = dq_i;
				8'h40: lr &= dq_i;
				8'h88: if (b == 8'h00 && lr[0])
					ext[addr_i[6:0]] &= dq_i;
				default: ;
				endcase
			else if (mode == 8'hC0 && sh[7:0] == 8'h80 && d == 8'h30)
				nvp = lock ? '1 : nvp;
			else if (mode == 8'h60 && d == 8'h29
				&& sh[95:64] == 32'h00250003)
				if ($realtime - t_unl < 1000.0)
					too_close++;
				else
				begin
					t_unl = $realtime;
					if (sh[63:0] == {pw[0], pw[1], pw[2], pw[3]})
						lock = 1'b1;
				end
			sh = {sh[95:0], dq_i};
		end
	end

	always_comb
	begin
		case (mode)
		8'hC0: rv = {15'h0000, nvp[addr_i[23:16]]};
		8'hE0: rv = {15'h0000, vol[addr_i[23:16]]};
		8'h50: rv = {15'h0000, lock};
		8'h40: rv = lr;
		8'h60: rv = lr[PWD_LOCK_BIT] ? pw[addr_i[1:0]]
			: 16'h00FF;
		8'h88: rv = (addr_i[23:16] == 8'h00) ? ext[addr_i[6:0]]
			: ~addr_i[15:0];
		default: rv = ~addr_i[15:0];
		endcase
	end

	always @(posedge oe_n_i) last = rv;
	// Released bus shows the inverse, so a stale value never passes
	assign #(RD_DLY_NS) dq_o = (!ce_n_i && !oe_n_i) ? rv : ~last;
endmodule

/* File: verification/fbp_ctrl_chk.sv */
// Port checker for the flash protection host controller.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/10ps
module fbp_ctrl_chk
	import fbp_pkg::*;
(
	input wire logic          clk_i,
	input wire logic          sys_rst_i,
	input wire logic          hreadyout_o,
	input wire logic          hresp_o,
	input wire logic          flash_dq_oe_o,
	input wire logic [AW-1:0] flash_addr_o,
	input wire logic          flash_ce_n_o,
	input wire logic          flash_oe_n_o,
	input wire logic          flash_we_n_o,
	input wire logic          accel_program_voltage_level_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	property p_okay; !hresp_o && hreadyout_o; endproperty
	a_okay: assert property (p_okay) else $error("bad bus response");
	property p_we_len; $fell(flash_we_n_o) |-> ##17 !flash_we_n_o
		##1 flash_we_n_o; endproperty
	a_we_len: assert property (p_we_len) else $error("write strobe len");
	property p_ce_tail; $rose(flash_we_n_o) |-> !flash_ce_n_o
		##[4:6] flash_ce_n_o; endproperty
	a_ce_tail: assert property (p_ce_tail) else $error("ce tail");
	property p_oe_len; $fell(flash_oe_n_o) |-> (!flash_oe_n_o)[*8]
		##[10:14] $rose(flash_oe_n_o); endproperty
	a_oe_len: assert property (p_oe_len) else $error("read strobe len");
	property p_nofight; flash_dq_oe_o |-> flash_oe_n_o; endproperty
	a_nofight: assert property (p_nofight) else $error("dq contention");
	property p_drv_ce; flash_dq_oe_o |-> !flash_ce_n_o; endproperty
	a_drv_ce: assert property (p_drv_ce) else $error("dq outside cycle");
	property p_excl; !(!flash_oe_n_o && !flash_we_n_o); endproperty
	a_excl: assert property (p_excl) else $error("oe and we both low");
	property p_addr; !flash_ce_n_o && $past(!flash_ce_n_o)
		|-> $stable(flash_addr_o); endproperty
	a_addr: assert property (p_addr) else $error("address moved");
	property p_accel; $rose(accel_program_voltage_level_o)
		|-> flash_ce_n_o; endproperty
	a_accel: assert property (p_accel) else $error("accel mid cycle");

	c_wr: cover property ($fell(flash_we_n_o));
	c_rd: cover property ($fell(flash_oe_n_o));
	c_acc: cover property ($rose(accel_program_voltage_level_o));
endmodule

bind fbp_ctrl_top fbp_ctrl_chk i_chk (.clk_i(clk_i),
	.sys_rst_i(sys_rst_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
	.flash_dq_oe_o(flash_dq_oe_o), .flash_addr_o(flash_addr_o),
	.flash_ce_n_o(flash_ce_n_o), .flash_oe_n_o(flash_oe_n_o),
	.flash_we_n_o(flash_we_n_o),
	.accel_program_voltage_level_o(accel_program_voltage_level_o));

/* File: verification/fbp_tb.sv */
// Testbench: AHB register tasks drive protection command sequences.
// Assumes the behavioural flash model on the pins.
`timescale 1ns/10ps
module tb;
	import fbp_pkg::*;
	logic          clk_i, sys_rst_i, hsel, hwrite, hready, hresp;
	logic [31:0]   haddr, hwdata, hrdata, r;
	logic [1:0]    htrans;
	logic [2:0]    hsize;
	logic [DW-1:0] dq_o, dq_m;
	wire  [DW-1:0] dq_w;
	logic [AW-1:0] fa;
	logic          oe, ce_n, oe_n, we_n, wp_n, acc, wp_lvl, acc_lvl;
	int            bad_count, n_compared;

	fbp_ctrl_top i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
		.hready_i(hready), .hreadyout_o(hready), .hrdata_o(hrdata),
		.hresp_o(hresp), .flash_dq_i(dq_w), .flash_dq_o(dq_o),
		.flash_dq_oe_o(oe), .flash_addr_o(fa), .flash_ce_n_o(ce_n),
		.flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .flash_wp_n_o(wp_n),
		.accel_program_voltage_level_o(acc));
	assign dq_w = oe ? dq_o : dq_m;
	fbp_flash_model #(.RD_DLY_NS(50)) i_mem (.addr_i(fa), .dq_i(dq_w),
		.ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .dq_o(dq_m));

	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	task results;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= w;
		@(posedge clk_i);
		while (hready !== 1'b1) @(posedge clk_i);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk_i);
		while (hready !== 1'b1) @(posedge clk_i);
		r = hrdata;
	endtask

	task ctl;
		ahb(1'b1, REG_CTRL, {14'h0000, acc_lvl, wp_lvl, 16'h0000});
		repeat (2) @(posedge clk_i);
	endtask

	task op(input logic [3:0] o, input logic [23:0] a, input logic [15:0] d);
		ahb(1'b1, REG_ADDR, {8'h00, a});
		ahb(1'b1, REG_WDATA, {16'h0000, d});
		ahb(1'b1, REG_CTRL, {14'h0000, acc_lvl, wp_lvl, 7'h00, 1'b1,
			4'h0, o});
		repeat (2) @(posedge clk_i);
		do
			ahb(1'b0, REG_STATUS, 32'h0);
		while (r[0] !== 1'b0);
	endtask

	task st(input logic [2:0] m, input logic e);
		ahb(1'b0, REG_STATUS, 32'h0);
		chk(r & 32'h72, {25'h0, m, 2'h0, e, 1'b0});
	endtask

	task fr(input logic [23:0] a, input logic [15:0] e);
		op(OP_READ, a, 16'h0000);
		ahb(1'b0, REG_RD_LO, 32'h0);
		chk(r, {16'h0000, e});
	endtask

	initial
	begin
		// Several times the expected length of the run
		#200000;
		bad_count++;
		results;
	end

	initial
	begin
		sys_rst_i = 1'b1;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsel = 1'b1;
		hsize = HSIZE_WORD;
		{wp_lvl, acc_lvl, bad_count, n_compared} = {1'b1, 1'b0, 64'h0};
		repeat (5) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		chk({wp_n, acc}, 32'h2);
		st(3'h0, 1'b0);
		ahb(1'b0, REG_PWD_LO, 32'h0);
		chk(r, 32'hFFFFFFFF);
		ahb(1'b0, 8'h40, 32'h0);
		chk(r, 32'h0);
		fr(24'h030005, 16'hFFFA);
		for (int i = 0; i < 6; i++)
		begin
			op(i[3:0], 24'h0, 16'h0);
			st(i[2:0] + 3'h1, 1'b0);
			op(OP_EXIT, 24'h0, 16'h0);
			st(3'h0, 1'b0);
		end
		op(OP_ENTER_NVP, 24'h0, 16'h0);
		op(OP_ENTER_VOL, 24'h0, 16'h0);
		st(3'h3, 1'b1);
		op(OP_PROGRAM, 24'h050000, 16'h0000);
		fr(24'h050000, 16'h0000);
		fr(24'h060000, 16'h0001);
		op(OP_CLEAR_VOL, 24'h060000, 16'h0001);
		st(3'h3, 1'b1);
		op(OP_CLEAR_NVP, 24'h0, 16'h0);
		fr(24'h050000, 16'h0001);
		op(OP_PROGRAM, 24'h050000, 16'h0000);
		op(OP_EXIT, 24'h0, 16'h0);
		op(OP_ENTER_LOCKBIT, 24'h0, 16'h0);
		op(OP_PROGRAM, 24'h0, 16'h0);
		fr(24'h0, 16'h0000);
		op(OP_EXIT, 24'h0, 16'h0);
		op(OP_ENTER_NVP, 24'h0, 16'h0);
		op(OP_CLEAR_NVP, 24'h0, 16'h0);
		fr(24'h050000, 16'h0000);
		op(OP_EXIT, 24'h0, 16'h0);
		op(OP_ENTER_VOL, 24'h0, 16'h0);
		fr(24'h020000, 16'h0001);
		op(OP_PROGRAM, 24'h020000, 16'h0000);
		fr(24'h020000, 16'h0000);
		acc_lvl = 1'b1;
		ctl;
		chk({r[31:1], acc}, {r[31:1], 1'b0});
		st(3'h5, 1'b1);
		acc_lvl = 1'b0;
		op(OP_CLEAR_VOL, 24'h020000, 16'h0001);
		fr(24'h020000, 16'h0001);
		op(OP_EXIT, 24'h0, 16'h0);
		acc_lvl = 1'b1;
		ctl;
		chk({wp_n, acc}, 32'h3);
		{acc_lvl, wp_lvl} = 2'b00;
		ctl;
		chk({wp_n, acc}, 32'h0);
		wp_lvl = 1'b1;
		ahb(1'b1, REG_PWD_LO, 32'h13572468);
		ahb(1'b1, REG_PWD_HI, 32'h0F1E2D3C);
		op(OP_ENTER_PWD, 24'h0, 16'h0);
		op(OP_PROG_PWD, 24'h0, 16'h0);
		op(OP_READ_PWD, 24'h0, 16'h0);
		ahb(1'b0, REG_RD_LO, 32'h0);
		chk(r, 32'h13572468);
		ahb(1'b0, REG_RD_HI, 32'h0);
		chk(r, 32'h0F1E2D3C);
		for (int k = 0; k < 2; k++)
		begin
			ahb(1'b1, REG_PWD_LO, 32'h13572469 - k);
			op(OP_UNLOCK_PWD, 24'h0, 16'h0);
			op(OP_EXIT, 24'h0, 16'h0);
			op(OP_ENTER_LOCKBIT, 24'h0, 16'h0);
			fr(24'h0, k[15:0]);
			op(OP_EXIT, 24'h0, 16'h0);
			op(OP_ENTER_PWD, 24'h0, 16'h0);
		end
		op(OP_UNLOCK_PWD, 24'h0, 16'h0);
		op(OP_EXIT, 24'h0, 16'h0);
		chk(i_mem.too_close, 32'h0);
		op(OP_ENTER_EXT, 24'h0, 16'h0);
		op(OP_PROGRAM, 24'h000010, 16'h1234);
		fr(24'h000010, 16'h1234);
		op(OP_PROGRAM, 24'h000010, 16'hFF00);
		fr(24'h000010, 16'h1200);
		op(OP_EXIT, 24'h0, 16'h0);
		st(3'h0, 1'b0);
		fr(24'h000010, 16'hFFEF);
		ahb(1'b0, REG_ADDR, 32'h0);
		chk(r, 32'h00000010);
		op(OP_ENTER_LOCKREG, 24'h0, 16'h0);
		op(OP_PROGRAM, 24'h0, 16'hFFFA);
		fr(24'h0, 16'hFFFA);
		op(OP_EXIT, 24'h0, 16'h0);
		op(OP_ENTER_EXT, 24'h0, 16'h0);
		op(OP_PROGRAM, 24'h000010, 16'h0000);
		fr(24'h000010, 16'h1200);
		op(OP_EXIT, 24'h0, 16'h0);
		op(OP_ENTER_PWD, 24'h0, 16'h0);
		op(OP_READ_PWD, 24'h0, 16'h0);
		ahb(1'b0, REG_RD_LO, 32'h0);
		chk(r, 32'h00FF00FF);
		op(OP_EXIT, 24'h0, 16'h0);
		op(4'hE, 24'h0, 16'h0);
		st(3'h0, 1'b1);
		results;
	end
endmodule
